// [rtl/pcs_pkg.sv]
// Shared constants and carrier types of the 10GBASE-R coding channel.
package pcs_pkg;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------

  // One single-rate MAC word: eight byte lanes, lane 0 in bits 7:0, one control bit per lane.
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] ctrl;
  } mac_word_type;

  // One 64b/66b block as it travels to or from the serial side.
  typedef struct packed {
    logic [1:0] hdr;
    logic [63:0] payload;
  } line_block_type;

  // Width of a MAC word when flattened for the buffer.
  localparam int WORD_BITS = $bits(mac_word_type);

  // ---------------------------------------------------------------
  // Block coding
  // ---------------------------------------------------------------

  localparam logic [1:0] HDR_DATA = 2'h1; // Sync header of an all-data block.
  localparam logic [1:0] HDR_CTRL = 2'h2; // Sync header of a control block.
  localparam logic [7:0] TYPE_IDLE = 8'h1E; // Block type of an all-control block.
  localparam logic [7:0] TYPE_START = 8'h78; // Block type of a start in lane 0.
  localparam logic [7:0] TYPE_TERM = 8'h87; // Block type of a terminate in lane 0.
  localparam logic [7:0] CHAR_IDLE = 8'h07; // MAC idle character.
  localparam logic [7:0] CHAR_START = 8'hFB; // MAC start character.
  localparam logic [7:0] CHAR_TERM = 8'hFD; // MAC terminate character.
  localparam logic [7:0] CHAR_ERROR = 8'hFE; // MAC error character.
  localparam logic [6:0] CODE_ERROR = 7'h1E; // Seven-bit line error code.
  localparam logic [7:0] CTRL_ALL = 8'hFF; // Every lane is a control character.
  localparam logic [7:0] CTRL_LANE0 = 8'h01; // Only lane 0 is a control character.
  localparam int SCR_TAP_A = 38; // Scrambler taps of the polynomial x^58 + x^39 + 1.
  localparam int SCR_TAP_B = 57;

  // ---------------------------------------------------------------
  // Lock, framing and rates
  // ---------------------------------------------------------------

  localparam logic [5:0] LOCK_LAST = 6'h3F; // 64 good headers in a row give block lock.
  localparam logic [4:0] FEC_FRAME_LAST = 5'h1F; // A correction frame spans 32 blocks.
  localparam logic [2:0] FEC_LOCK_GOOD = 3'h4; // Markers in place needed for frame lock.
  localparam logic [15:0] PN_SEED = 16'hACE1; // Start value of the frame sequence.
  localparam logic [1:0] LAT_PLAIN = 2'h1; // Transmit latency in cycles, plain mode.
  localparam logic [1:0] LAT_TIMING = 2'h2; // Transmit latency in cycles, register mode.
  localparam int LINE_RATE_KBPS = 10312500; // Serial line rate in kbit/s.
  localparam int MAC_CLK_KHZ = 156250; // Effective MAC word rate in kHz.
  localparam int MCLK_PERIOD_NS = 40; // Period of the block clock.

endpackage : pcs_pkg

// [rtl/pair_buffer.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module pair_buffer
  import pcs_pkg::*;
#(
  parameter int WIDTH = WORD_BITS
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  // Whole state of the buffer: two slots, two pointers and a fill count.
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd_idx;
    logic wr_idx;
    logic [1:0] count;
  } buf_state_type;

  buf_state_type state_q; // Registered state.
  buf_state_type state_d; // Next state.
  logic push; // A word enters this cycle.
  logic pop; // A word leaves this cycle.

  // Ready and valid come straight from the count, so neither side waits on the other.
  assign in_ready = (state_q.count != 2'h2);
  assign out_valid = (state_q.count != 2'h0);
  assign out_data = state_q.mem[state_q.rd_idx];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Push and pop may happen together; the count then stays put.
  always_comb
  begin
    state_d = state_q;
    if (push)
    begin
      state_d.mem[state_q.wr_idx] = in_data;
      state_d.wr_idx = ~state_q.wr_idx;
    end
    if (pop)
    begin
      state_d.rd_idx = ~state_q.rd_idx;
    end
    state_d.count = state_q.count + 2'(push) - 2'(pop);
  end

  // Register the state; reset empties the buffer.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

endmodule : pair_buffer

// [rtl/pcs_channel.sv]
// Single-lane 64b/66b coding channel with optional frame correction stage.
`timescale 1ns/100ps
module pcs_channel
  import pcs_pkg::*;
#(
  parameter int PMA_WIDTH = 40
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic fec_en,
  input wire logic timing_mode,
  input wire logic tx_valid,
  input mac_word_type tx_word,
  output line_block_type pma_tx_block,
  output logic pma_tx_valid,
  input wire logic pma_rx_valid,
  input line_block_type pma_rx_block,
  output mac_word_type rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_block_lock,
  output logic rx_fec_lock,
  output logic rx_frame_marker,
  output logic rx_idle_dropped,
  output logic [1:0] tx_latency,
  output logic [19:0] word_clk_khz,
  output logic [19:0] mac_clk_khz
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  // All registers of the channel in one record.
  typedef struct packed {
    logic [57:0] tx_scr; // Transmit scrambler history.
    line_block_type tx_blk1; // First transmit stage.
    logic tx_v1;
    line_block_type tx_blk2; // Extra stage used in register mode.
    logic tx_v2;
    logic [4:0] tx_fcnt; // Block position inside the transmit frame.
    logic [15:0] tx_pn; // Transmit frame sequence.
    logic [1:0] tx_lat; // Reported transmit latency, set from the mode.
    logic [57:0] rx_scr; // Receive descrambler history.
    logic [5:0] lock_cnt; // Good headers seen in a row.
    logic blk_lock;
    logic [4:0] rx_fcnt; // Expected block position in the receive frame.
    logic [15:0] rx_pn; // Receive frame sequence.
    logic [2:0] fec_good; // Markers found in place.
    logic fec_lock;
    logic marker; // Frame marker seen, one-cycle pulse.
    logic drop; // Idle word deleted, one-cycle pulse.
  } chan_state_type;

  chan_state_type state_q; // Registered state.
  chan_state_type state_d; // Next state.
  logic buf_in_valid; // Decoded word offered to the buffer.
  logic buf_in_ready; // Buffer can take a word.
  mac_word_type buf_in_word; // Decoded word.
  logic [WORD_BITS-1:0] buf_out_flat; // Word leaving the buffer.

  // ---------------------------------------------------------------
  // Coding helpers
  // ---------------------------------------------------------------

  // Map one MAC word onto a block; only the common control shapes are coded.
  function automatic line_block_type encode(mac_word_type w);
    line_block_type b;
    b.hdr = HDR_CTRL;
    if (w.ctrl == 8'h00)
    begin
      b.hdr = HDR_DATA;
      b.payload = w.data;
    end
    else if (w.ctrl == CTRL_ALL && w.data == {8{CHAR_IDLE}})
    begin
      b.payload = {56'h0, TYPE_IDLE};
    end
    else if (w.ctrl == CTRL_LANE0 && w.data[7:0] == CHAR_START)
    begin
      b.payload = {w.data[63:8], TYPE_START};
    end
    else if (w.ctrl == CTRL_ALL && w.data == {{7{CHAR_IDLE}}, CHAR_TERM})
    begin
      b.payload = {56'h0, TYPE_TERM};
    end
    else
    begin
      // Shapes the coder does not know leave as line errors.
      b.payload = {{8{CODE_ERROR}}, TYPE_IDLE};
    end
    return b;
  endfunction : encode

  // Map one block back onto a MAC word, lane 0 first.
  function automatic mac_word_type decode(line_block_type b);
    mac_word_type w;
    w.ctrl = CTRL_ALL;
    w.data = {8{CHAR_ERROR}};
    if (b.hdr == HDR_DATA)
    begin
      w.ctrl = 8'h00;
      w.data = b.payload;
    end
    else if (b.payload[7:0] == TYPE_IDLE && b.payload[63:8] == 56'h0)
    begin
      w.data = {8{CHAR_IDLE}};
    end
    else if (b.payload[7:0] == TYPE_START)
    begin
      w.ctrl = CTRL_LANE0;
      w.data = {b.payload[63:8], CHAR_START};
    end
    else if (b.payload[7:0] == TYPE_TERM)
    begin
      w.data = {{7{CHAR_IDLE}}, CHAR_TERM};
    end
    return w;
  endfunction : decode

  // Self-synchronous scrambler, bit 0 first; returns new history and scrambled word.
  function automatic logic [121:0] scramble(logic [57:0] st, logic [63:0] d);
    logic [63:0] o;
    logic [57:0] s;
    s = st;
    o = '0;
    for (int i = 0; i < 64; i++)
    begin
      o[i] = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s = {s[56:0], o[i]};
    end
    return {s, o};
  endfunction : scramble

  // Matching descrambler: the history takes the received bits.
  function automatic logic [121:0] descramble(logic [57:0] st, logic [63:0] d);
    logic [63:0] o;
    logic [57:0] s;
    s = st;
    o = '0;
    for (int i = 0; i < 64; i++)
    begin
      o[i] = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s = {s[56:0], d[i]};
    end
    return {s, o};
  endfunction : descramble

  // Frame sequence step, a 16-bit Galois register.
  function automatic logic [15:0] pn_next(logic [15:0] p);
    return {1'b0, p[15:1]} ^ (p[0] ? 16'hB400 : 16'h0000);
  endfunction : pn_next

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Transmit coding, receive decoding, lock tracking and idle deletion in one pass.
  always_comb
  begin
    line_block_type tb;
    line_block_type rb;
    logic [121:0] sr;
    logic [15:0] pn_use;
    logic mk;
    logic t_bit;
    logic hdr_ok;
    tb = '0;
    rb = '0;
    sr = '0;
    pn_use = '0;
    mk = 1'b0;
    t_bit = 1'b0;
    hdr_ok = 1'b0;
    state_d = state_q;
    state_d.marker = 1'b0;
    state_d.drop = 1'b0;
    buf_in_valid = 1'b0;
    buf_in_word = '0;

    // Transmit: one MAC word becomes one scrambled block.
    state_d.tx_v1 = tx_valid;
    if (tx_valid)
    begin
      tb = encode(tx_word);
      sr = scramble(state_q.tx_scr, tb.payload);
      state_d.tx_scr = sr[121:64];
      tb.payload = sr[63:0];
      if (fec_en)
      begin
        // Header shrinks to one transcode bit; the other bit marks the frame start.
        t_bit = (tb.hdr == HDR_DATA);
        mk = (state_q.tx_fcnt == 5'h00);
        pn_use = mk ? PN_SEED : state_q.tx_pn;
        tb.hdr = {mk, t_bit};
        tb.payload = tb.payload ^ {4{pn_use}};
        state_d.tx_pn = pn_next(pn_use);
        state_d.tx_fcnt = state_q.tx_fcnt + 5'h01;
      end
      state_d.tx_blk1 = tb;
    end
    // Register mode adds one stage; the reported latency follows the mode.
    state_d.tx_blk2 = state_q.tx_blk1;
    state_d.tx_v2 = state_q.tx_v1;
    state_d.tx_lat = timing_mode ? LAT_TIMING : LAT_PLAIN;

    // Receive: strip the correction framing first, so coding sees plain blocks.
    if (pma_rx_valid)
    begin
      rb = pma_rx_block;
      if (fec_en)
      begin
        mk = rb.hdr[1];
        state_d.marker = mk;
        if (mk && state_q.rx_fcnt != 5'h00)
        begin
          // Marker out of place: slip to it and start counting again.
          state_d.fec_good = 3'h0;
          state_d.fec_lock = 1'b0;
        end
        else if (mk && state_q.fec_good != FEC_LOCK_GOOD)
        begin
          state_d.fec_good = state_q.fec_good + 3'h1;
          state_d.fec_lock = (state_q.fec_good + 3'h1 == FEC_LOCK_GOOD);
        end
        else if (!mk && state_q.rx_fcnt == 5'h00)
        begin
          // Missing marker costs frame lock.
          state_d.fec_good = 3'h0;
          state_d.fec_lock = 1'b0;
        end
        pn_use = mk ? PN_SEED : state_q.rx_pn;
        state_d.rx_pn = pn_next(pn_use);
        state_d.rx_fcnt = mk ? 5'h01 : state_q.rx_fcnt + 5'h01;
        rb.payload = rb.payload ^ {4{pn_use}};
        rb.hdr = {~rb.hdr[0], rb.hdr[0]};
      end
      else
      begin
        state_d.fec_good = 3'h0;
        state_d.fec_lock = 1'b0;
      end
      // Block lock on sync headers.
      hdr_ok = (rb.hdr == HDR_DATA) || (rb.hdr == HDR_CTRL);
      if (!hdr_ok)
      begin
        state_d.lock_cnt = 6'h00;
        state_d.blk_lock = 1'b0;
      end
      else if (state_q.lock_cnt == LOCK_LAST)
      begin
        state_d.blk_lock = 1'b1;
      end
      else
      begin
        state_d.lock_cnt = state_q.lock_cnt + 6'h01;
      end
      sr = descramble(state_q.rx_scr, rb.payload);
      state_d.rx_scr = sr[121:64];
      rb.payload = sr[63:0];
      buf_in_word = decode(rb);
      // Idles are deleted while the buffer is full; this absorbs the ppm offset.
      if (state_q.blk_lock && (!fec_en || state_q.fec_lock))
      begin
        if (!buf_in_ready && buf_in_word == mac_word_type'{data: {8{CHAR_IDLE}}, ctrl: CTRL_ALL})
        begin
          state_d.drop = 1'b1;
        end
        else
        begin
          buf_in_valid = 1'b1;
        end
      end
    end
    else if (!fec_en)
    begin
      state_d.fec_good = 3'h0;
      state_d.fec_lock = 1'b0;
    end
  end

  // Register the state; reset clears every lock and stage.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer and outputs
  // ---------------------------------------------------------------

  // The buffer rides out short MAC stalls; words before lock are dropped, and a non-idle word offered while it is full is lost.
  pair_buffer #(
    .WIDTH(WORD_BITS)
  ) rx_buf (
    .mclk(mclk),
    .reset(reset),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(buf_out_flat)
  );

  assign rx_word = mac_word_type'(buf_out_flat);
  assign pma_tx_block = timing_mode ? state_q.tx_blk2 : state_q.tx_blk1;
  assign pma_tx_valid = timing_mode ? state_q.tx_v2 : state_q.tx_v1;
  assign tx_latency = state_q.tx_lat;
  assign rx_block_lock = state_q.blk_lock;
  assign rx_fec_lock = state_q.fec_lock;
  assign rx_frame_marker = state_q.marker;
  assign rx_idle_dropped = state_q.drop;
  assign word_clk_khz = 20'(LINE_RATE_KBPS / PMA_WIDTH);
  assign mac_clk_khz = 20'(MAC_CLK_KHZ);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  a_data_header: assert property (@(posedge mclk) disable iff (reset)
    tx_valid && tx_word.ctrl == 8'h00 && !fec_en && !timing_mode ##1 !timing_mode
    |-> pma_tx_valid && pma_tx_block.hdr == HDR_DATA)
    else $error("data word not sent with data header");
  a_rx_stall_hold: assert property (@(posedge mclk) disable iff (reset)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("receive word changed while stalled");
  a_latency_report: assert property (@(posedge mclk) disable iff (reset)
    timing_mode |=> tx_latency == LAT_TIMING)
    else $error("latency report wrong in register mode");
  a_register_delay: assert property (@(posedge mclk) disable iff (reset)
    timing_mode [*3] ##0 $past(tx_valid, 2) |-> pma_tx_valid)
    else $error("register mode did not deliver after two cycles");
  a_fec_marker: assert property (@(posedge mclk) disable iff (reset)
    tx_valid && fec_en && state_q.tx_fcnt == 5'h00 && !timing_mode ##1 !timing_mode
    |-> pma_tx_block.hdr[1])
    else $error("frame marker missing at frame start");
  a_fec_lock_off: assert property (@(posedge mclk) disable iff (reset)
    !fec_en |=> !rx_fec_lock)
    else $error("frame lock held without correction");
  a_plain_headers: assert property (@(posedge mclk) disable iff (reset)
    pma_tx_valid && !timing_mode && !$past(fec_en)
    |-> pma_tx_block.hdr == HDR_DATA || pma_tx_block.hdr == HDR_CTRL)
    else $error("illegal sync header without correction");
  a_idle_delete: assert property (@(posedge mclk) disable iff (reset)
    rx_idle_dropped |-> $past(!buf_in_ready) && $past(pma_rx_valid))
    else $error("idle deleted while buffer had room");
  c_fec_lock: cover property (@(posedge mclk) disable iff (reset) $rose(rx_fec_lock));
  c_idle_drop: cover property (@(posedge mclk) disable iff (reset) rx_idle_dropped);
  c_rx_stall: cover property (@(posedge mclk) disable iff (reset) rx_valid && !rx_ready ##1 rx_valid && rx_ready);

endmodule : pcs_channel

// [test/mac_model.sv]
// Receive-side MAC model that takes words from the coding channel.
`timescale 1ns/100ps
module mac_model
  import pcs_pkg::*;
(
  input wire logic mclk,
  input wire logic stall,
  input mac_word_type rx_word,
  input wire logic rx_valid,
  output logic rx_ready
);
  // ---------------------------------------------------------------
  // Word sink
  // ---------------------------------------------------------------

  // Words taken, oldest first; the bench inspects and clears it.
  mac_word_type got[$];

  // The MAC backs off only when the bench asks it to stall, so back-pressure is under test control.
  assign rx_ready = !stall;

  // Receive words are taken on the same clock that feeds transmit, so no offset exists here.
  always @(posedge mclk)
  begin
    // A whole 72-bit word changes hands where valid and ready meet.
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      got.push_back(rx_word);
    end
  end
endmodule : mac_model

// [test/pcs_channel_tb.sv]
// Self-checking bench of the single-lane coding channel in line loopback.
`timescale 1ns/100ps
module pcs_channel_tb;
  import pcs_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and wiring
  // ---------------------------------------------------------------

  logic mclk = 1'b0; // Block clock.
  logic reset = 1'b1; // Asynchronous reset, held at start.
  logic fec_en = 1'b0; // Correction stage select.
  logic timing_mode = 1'b0; // Register-mode transmit select.
  logic tx_valid = 1'b0; // Transmit word strobe.
  mac_word_type tx_word = '0; // Transmit word.
  logic stall = 1'b0; // Tells the MAC model to hold off.
  logic pma_rx_valid = 1'b0; // Looped-back block strobe.
  line_block_type pma_rx_block = '0; // Looped-back block.
  line_block_type pma_tx_block;
  logic pma_tx_valid;
  mac_word_type rx_word;
  logic rx_valid;
  logic rx_ready;
  logic rx_block_lock;
  logic rx_fec_lock;
  logic rx_frame_marker;
  logic rx_idle_dropped;
  int markers = 0; // Frame-marker pulses since the last reset.
  logic [1:0] tx_latency;
  logic [19:0] word_clk_khz;
  logic [19:0] mac_clk_khz;
  int errors = 0; // Mismatches seen.
  int total_checks = 0; // Comparisons made.
  int cycles = 0; // Watchdog count.
  localparam mac_word_type IDLE_W = '{data: {8{CHAR_IDLE}}, ctrl: CTRL_ALL};
  localparam mac_word_type DATA_W = '{data: 64'h0123456789ABCDEF, ctrl: 8'h00};

  // Period of 40 ns gives the 25 MHz block clock.
  initial
  begin
    forever #20 mclk = ~mclk;
  end

  // Serial side is looped back; sampled on the falling edge where the outputs have settled.
  always @(negedge mclk)
  begin
    pma_rx_block <= pma_tx_block;
    pma_rx_valid <= pma_tx_valid;
  end

  pcs_channel #(.PMA_WIDTH(40)) u_dut (.mclk(mclk), .reset(reset), .fec_en(fec_en), .timing_mode(timing_mode),
    .tx_valid(tx_valid), .tx_word(tx_word), .pma_tx_block(pma_tx_block), .pma_tx_valid(pma_tx_valid),
    .pma_rx_valid(pma_rx_valid), .pma_rx_block(pma_rx_block), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_block_lock(rx_block_lock), .rx_fec_lock(rx_fec_lock),
    .rx_frame_marker(rx_frame_marker),
    .rx_idle_dropped(rx_idle_dropped), .tx_latency(tx_latency), .word_clk_khz(word_clk_khz),
    .mac_clk_khz(mac_clk_khz));

  mac_model u_mac (.mclk(mclk), .stall(stall), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));

  // Counts marker pulses away from the launching edge; reset clears the count, so each scenario starts at zero.
  always @(negedge mclk)
  begin
    if (reset)
      markers = 0;
    else if (rx_frame_marker === 1'b1)
      markers++;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------

  // Compares one value with its expectation; case inequality keeps unknowns from matching.
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Resets the channel for 8 cycles with the given modes applied.
  task automatic restart(input logic fec, input logic tmode);
    @(negedge mclk);
    reset = 1'b1;
    fec_en = fec;
    timing_mode = tmode;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    u_mac.got.delete();
  endtask : restart

  // Sends a word n times back to back, then drops the strobe.
  task automatic send(input mac_word_type w, input int n);
    repeat (n)
    begin
      @(negedge mclk);
      tx_valid = 1'b1;
      tx_word = w;
    end
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask : send

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------

  // Rate reports must follow line rate over width and the MAC word rate.
  task automatic t_rates();
    check("word_clk_khz", 72'(word_clk_khz), 72'(LINE_RATE_KBPS / 40));
    check("mac_clk_khz", 72'(mac_clk_khz), 72'(MAC_CLK_KHZ));
  endtask : t_rates

  // One word in; the block must appear after the mode's pipeline depth with the right header.
  task automatic t_latency(input logic tmode, input mac_word_type w, input logic [1:0] hdr);
    int n;
    restart(1'b0, tmode);
    repeat (3) @(negedge mclk);
    n = 0;
    send(w, 1);
    while (pma_tx_valid !== 1'b1 && n < 10)
    begin
      n++;
      @(negedge mclk);
    end
    check("tx latency", 72'(n + 1), tmode ? 72'(LAT_TIMING) : 72'(LAT_PLAIN));
    check("tx_latency port", 72'(tx_latency), tmode ? 72'(LAT_TIMING) : 72'(LAT_PLAIN));
    check("sync header", 72'(pma_tx_block.hdr), 72'(hdr));
  endtask : t_latency

  // Loopback: after lock a data word must come back whole, with or without the correction stage.
  task automatic t_loop(input logic fec);
    int k;
    restart(fec, 1'b0);
    send(IDLE_W, fec ? 200 : 80);
    check("block lock", 72'(rx_block_lock), 72'h1);
    if (fec)
      check("fec lock", 72'(rx_fec_lock), 72'h1);
    // 200 framed words open a frame every 32 words, so 7 markers; none without correction.
    check("frame markers", 72'(markers), fec ? 72'h7 : 72'h0);
    u_mac.got.delete();
    send(DATA_W, 1);
    send(IDLE_W, 6);
    repeat (4) @(negedge mclk);
    k = 0;
    while (k < u_mac.got.size() && u_mac.got[k].ctrl === CTRL_ALL)
      k++;
    check("looped word", (k < u_mac.got.size()) ? u_mac.got[k] : 72'h0, DATA_W);
  endtask : t_loop

  // A stalled MAC fills the two-entry buffer; further idles must be deleted, then the buffer drains.
  task automatic t_stall();
    int drops;
    t_loop(1'b0);
    stall = 1'b1;
    drops = 0;
    tx_valid = 1'b1;
    tx_word = IDLE_W;
    repeat (8)
    begin
      @(negedge mclk);
      drops += (rx_idle_dropped === 1'b1);
    end
    tx_valid = 1'b0;
    repeat (3)
    begin
      @(negedge mclk);
      drops += (rx_idle_dropped === 1'b1);
    end
    check("idle deleted", 72'(drops > 0), 72'h1);
    check("held while stalled", 72'(rx_valid), 72'h1);
    stall = 1'b0;
    repeat (4) @(negedge mclk);
    check("drained", 72'(rx_valid), 72'h0);
  endtask : t_stall

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------

  initial
  begin
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    t_rates();
    t_latency(1'b0, DATA_W, HDR_DATA);
    t_latency(1'b0, IDLE_W, HDR_CTRL);
    t_latency(1'b1, DATA_W, HDR_DATA);
    t_loop(1'b0);
    t_loop(1'b1);
    t_stall();
    tally_and_finish();
  end

  // A hang counts as a mismatch; the whole run needs well under 3000 cycles.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end
endmodule : pcs_channel_tb
